// [gam_defs.vh]
// gam_defs.vh: constants for the genset anomaly monitor
// assumes a 100 MHz clock and second-based timer settings
`ifndef GAM_DEFS_VH
`define GAM_DEFS_VH
`define GAM_CLK_HZ 32'h05f5e100
`define GAM_MSK_OIL_HI 2
`define GAM_MSK_OIL_MAX 3
`define GAM_MSK_WIF 8
`define GAM_MSK_CUM_WRN_CLS 13
`define GAM_MSK_CUM_WRN 14
`define GAM_MSK_CUM_ALM 15
`define GAM_PHASES_3 4'h3
`define GAM_PSEQ_AUTO 2'h0
`define GAM_PSEQ_CW 2'h1
`define GAM_PSEQ_CCW 2'h2
`define GAM_PWR_ERR_S 16'h0005
`define GAM_ACT_WARN 2'h0
`define GAM_ACT_UNLOAD 2'h1
`define GAM_ACT_DEACT 2'h2
`define GAM_ACT_ALARM 2'h3
`define GAM_PERM_MAN 0
`define GAM_PERM_AUTO 1
`define GAM_PERM_TEST 2
`define GAM_PERM_REM 3
`define GAM_PERM_MASTER 7
`define GAM_MODE_MAN 2'h0
`define GAM_MODE_AUTO 2'h1
`define GAM_MODE_TEST 2'h2
`define GAM_MODE_REM 2'h3
`endif

// [gam_persist.v]
// gam_persist.v: persistence timer, condition held for a number of seconds
// assumes a one-cycle seconds tick shared by all timers
`timescale 1ns/1ps
module gam_persist (
	clk,
	nrst,
	cond,
	tick,
	delay_s,
	expired
);
	input wire clk;
	input wire nrst;
	input wire cond;
	input wire tick;
	input wire [15:0] delay_s;
	output wire expired;
	reg [16:0] cnt_q;
	// zero delay never expires, which disables the check
	// the shared tick can land just after cond rises, so one tick past the delay is awaited:
	// up to a second late, never early
	assign expired = cond && (delay_s != 16'h0000) && (cnt_q > {1'b0, delay_s});
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 17'h00000;
		end else if (!cond) begin
			cnt_q <= 17'h00000;
		end else if (tick && cnt_q != 17'h1ffff) begin
			cnt_q <= cnt_q + 17'h00001;
		end
	end
endmodule // gam_persist

// [gam_monitor.v]
// gam_monitor.v: anomaly detection for a generator-set controller
// assumes all inputs synchronous to clk and measurements already scaled
//
// Operation
// - raise oil and water faults unless masked
// - engine-bus checks only when engine bus active
// - cumulative bus warning, mask bit 14
// - cumulative bus alarm, mask bit 15
// - bit 13 turns cumulative alarm into warning
// - warn on control bus-off state
// - warn on duplicate node address
// - warn on wrong generator count, zero disables
// - negative sequence needs fuel, run, three phases
// - neg-seq current third of rotated vector sum
// - rotation direction from phase sequence selection
// - neg-seq trip after delay, zero disables
// - earth breaker close failure with set action
// - earth breaker open failure warning
// - earth breaker checks not in manual mode
// - active power error after fixed five seconds
// - power error action, override makes it warning
// - parallel limit opens breaker until acknowledge, except during generator transfer
// - reclose after load drop despite warning
// - mains opening permitted per permit mask
`timescale 1ns/1ps
`include "gam_defs.vh"
module gam_monitor (
	input wire clk,
	input wire nrst,
	input wire eng_bus_active,
	input wire avr_bus_cfg,
	input wire mixer_bus_cfg,
	input wire [15:0] can_disable_mask,
	input wire ecu_oil_temp_high,
	input wire ecu_oil_temp_max,
	input wire ecu_water_in_fuel,
	input wire ecu_any_warn,
	input wire avr_any_warn,
	input wire mixer_any_warn,
	input wire ecu_any_alarm,
	input wire avr_any_alarm,
	input wire mixer_any_alarm,
	input wire parallel_control_bus_en,
	input wire pcb_bus_off,
	input wire pcb_addr_dup,
	input wire [7:0] pcb_gen_count,
	input wire [7:0] pcb_gen_expected,
	input wire fuel_active,
	input wire engine_start_stop,
	input wire [3:0] phase_count,
	input wire current_on_gen,
	input wire [1:0] phase_seq_sel,
	input wire volt_rot_ccw,
	input wire signed [15:0] i1_re,
	input wire signed [15:0] i1_im,
	input wire signed [15:0] i2_re,
	input wire signed [15:0] i2_im,
	input wire signed [15:0] i3_re,
	input wire signed [15:0] i3_im,
	input wire [15:0] neg_seq_limit,
	input wire [15:0] neg_seq_delay_s,
	input wire [1:0] op_mode,
	input wire earth_breaker_output_func,
	input wire earth_feedback_input_func,
	input wire earth_close_cmd,
	input wire earth_open_cmd,
	input wire earth_fb_closed,
	input wire [15:0] earth_fb_delay_s,
	input wire [1:0] earth_close_action,
	input wire in_parallel,
	input wire signed [15:0] power_delivered,
	input wire signed [15:0] power_setpoint,
	input wire [15:0] power_err_thresh,
	input wire [1:0] power_err_action,
	input wire prot_override,
	input wire total_override,
	input wire grid_parallel,
	input wire [15:0] grid_limit_s,
	input wire [7:0] mains_perm_mask,
	input wire master_breaker_open_fail,
	input wire gen_transfer_active,
	input wire load_fits_gen,
	input wire operator_ack,
	output reg warn_oil_temp_high,
	output reg alarm_oil_temp_max,
	output reg warn_water_in_fuel,
	output reg warn_bus_cumulative,
	output reg anom_bus_alarm,
	output reg anom_bus_alarm_is_warn,
	output reg warn_pcb_bus_off,
	output reg warn_pcb_addr_dup,
	output reg warn_pcb_gen_count,
	output reg [15:0] neg_seq_current,
	output reg deact_neg_seq,
	output reg anom_earth_close_fail,
	output reg [1:0] earth_close_fail_action,
	output reg warn_earth_open_fail,
	output reg anom_power_err,
	output reg [1:0] power_err_action_out,
	output reg warn_grid_limit,
	output reg generator_breaker_force_open,
	output reg generator_breaker_auto_close,
	output reg mains_breaker_open_permit
);

	localparam [31:0] CYC_PER_S = `GAM_CLK_HZ;
	localparam [15:0] PWR_ERR_S = `GAM_PWR_ERR_S;
	// cos/sin of 120 degrees in q1.14; 240 is the conjugate
	localparam signed [15:0] C120 = -16'sd8192;
	localparam signed [15:0] S120 = 16'sd14189;

	reg [31:0] pre_q;
	wire tick;
	assign tick = (pre_q == CYC_PER_S - 32'd1);
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pre_q <= 32'h0;
		end else if (tick) begin
			pre_q <= 32'h0;
		end else begin
			pre_q <= pre_q + 32'd1;
		end
	end

	// rotation sign: positive means +120 on phase two, +240 on phase three
	reg rot_l2_120;
	always @* begin
		case (phase_seq_sel)
		`GAM_PSEQ_CW: rot_l2_120 = 1'b1;
		`GAM_PSEQ_CCW: rot_l2_120 = 1'b0;
		`GAM_PSEQ_AUTO: rot_l2_120 = !volt_rot_ccw;
		default: rot_l2_120 = 1'b1;
		endcase
	end
	wire signed [15:0] s2;
	wire signed [15:0] s3;
	assign s2 = rot_l2_120 ? S120 : -S120;
	assign s3 = rot_l2_120 ? -S120 : S120;
	wire signed [31:0] r2_re;
	wire signed [31:0] r2_im;
	wire signed [31:0] r3_re;
	wire signed [31:0] r3_im;
	assign r2_re = (i2_re * C120 - i2_im * s2) >>> 14;
	assign r2_im = (i2_re * s2 + i2_im * C120) >>> 14;
	assign r3_re = (i3_re * C120 - i3_im * s3) >>> 14;
	assign r3_im = (i3_re * s3 + i3_im * C120) >>> 14;
	wire signed [31:0] sum_re;
	wire signed [31:0] sum_im;
	assign sum_re = {{16{i1_re[15]}}, i1_re} + r2_re + r3_re;
	assign sum_im = {{16{i1_im[15]}}, i1_im} + r2_im + r3_im;
	wire [31:0] abs_re;
	wire [31:0] abs_im;
	assign abs_re = sum_re[31] ? -sum_re : sum_re;
	assign abs_im = sum_im[31] ? -sum_im : sum_im;
	// magnitude as the larger of max and 7/8 max + min/2: shifts only, within about 3 percent
	wire [31:0] hi;
	wire [31:0] lo;
	wire [31:0] blend;
	wire [31:0] mag;
	assign hi = (abs_re > abs_im) ? abs_re : abs_im;
	assign lo = (abs_re > abs_im) ? abs_im : abs_re;
	assign blend = hi - (hi >> 3) + (lo >> 1);
	assign mag = (blend > hi) ? blend : hi;
	wire [31:0] mag3;
	assign mag3 = mag / 32'd3;

	wire neg_seq_en;
	assign neg_seq_en = fuel_active && !engine_start_stop && (phase_count == `GAM_PHASES_3)
		&& current_on_gen;
	wire ns_exp;
	gam_persist u_ns (
		.clk(clk),
		.nrst(nrst),
		.cond(neg_seq_en && (neg_seq_current > neg_seq_limit)),
		.tick(tick),
		.delay_s(neg_seq_delay_s),
		.expired(ns_exp)
	);

	wire auto_like;
	assign auto_like = (op_mode != `GAM_MODE_MAN);
	wire earth_ok;
	assign earth_ok = earth_breaker_output_func && earth_feedback_input_func && auto_like;
	wire ec_exp;
	wire eo_exp;
	gam_persist u_ec (
		.clk(clk),
		.nrst(nrst),
		.cond(earth_ok && earth_close_cmd && !earth_fb_closed),
		.tick(tick),
		.delay_s(earth_fb_delay_s),
		.expired(ec_exp)
	);
	gam_persist u_eo (
		.clk(clk),
		.nrst(nrst),
		.cond(earth_ok && earth_open_cmd && earth_fb_closed),
		.tick(tick),
		.delay_s(earth_fb_delay_s),
		.expired(eo_exp)
	);

	wire signed [16:0] pdiff;
	assign pdiff = {power_delivered[15], power_delivered} - {power_setpoint[15], power_setpoint};
	wire [16:0] pabs;
	assign pabs = pdiff[16] ? -pdiff : pdiff;
	wire pe_exp;
	gam_persist u_pe (
		.clk(clk),
		.nrst(nrst),
		.cond(in_parallel && (pabs > {1'b0, power_err_thresh})),
		.tick(tick),
		.delay_s(PWR_ERR_S),
		.expired(pe_exp)
	);

	wire gl_exp;
	gam_persist u_gl (
		.clk(clk),
		.nrst(nrst),
		.cond(grid_parallel),
		.tick(tick),
		.delay_s(grid_limit_s),
		.expired(gl_exp)
	);

	reg perm_mode;
	always @* begin
		case (op_mode)
		`GAM_MODE_MAN: perm_mode = mains_perm_mask[`GAM_PERM_MAN];
		`GAM_MODE_AUTO: perm_mode = mains_perm_mask[`GAM_PERM_AUTO];
		`GAM_MODE_TEST: perm_mode = mains_perm_mask[`GAM_PERM_TEST];
		`GAM_MODE_REM: perm_mode = mains_perm_mask[`GAM_PERM_REM];
		default: perm_mode = 1'b0;
		endcase
	end

	wire bus_any_cfg;
	assign bus_any_cfg = eng_bus_active || avr_bus_cfg || mixer_bus_cfg;
	// latched parallel-limit warning: a new expiry wins over an acknowledge
	wire gl_set;
	assign gl_set = gl_exp && !warn_grid_limit;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			warn_oil_temp_high <= 1'b0;
			alarm_oil_temp_max <= 1'b0;
			warn_water_in_fuel <= 1'b0;
			warn_bus_cumulative <= 1'b0;
			anom_bus_alarm <= 1'b0;
			anom_bus_alarm_is_warn <= 1'b0;
			warn_pcb_bus_off <= 1'b0;
			warn_pcb_addr_dup <= 1'b0;
			warn_pcb_gen_count <= 1'b0;
			neg_seq_current <= 16'h0000;
			deact_neg_seq <= 1'b0;
			anom_earth_close_fail <= 1'b0;
			earth_close_fail_action <= 2'h0;
			warn_earth_open_fail <= 1'b0;
			anom_power_err <= 1'b0;
			power_err_action_out <= 2'h0;
			warn_grid_limit <= 1'b0;
			generator_breaker_force_open <= 1'b0;
			generator_breaker_auto_close <= 1'b0;
			mains_breaker_open_permit <= 1'b0;
		end else begin
			warn_oil_temp_high <= eng_bus_active && ecu_oil_temp_high
				&& !can_disable_mask[`GAM_MSK_OIL_HI];
			alarm_oil_temp_max <= eng_bus_active && ecu_oil_temp_max
				&& !can_disable_mask[`GAM_MSK_OIL_MAX];
			warn_water_in_fuel <= eng_bus_active && ecu_water_in_fuel
				&& !can_disable_mask[`GAM_MSK_WIF];
			warn_bus_cumulative <= bus_any_cfg && (ecu_any_warn || avr_any_warn || mixer_any_warn)
				&& !can_disable_mask[`GAM_MSK_CUM_WRN];
			anom_bus_alarm <= bus_any_cfg && (ecu_any_alarm || avr_any_alarm || mixer_any_alarm)
				&& !can_disable_mask[`GAM_MSK_CUM_ALM];
			anom_bus_alarm_is_warn <= can_disable_mask[`GAM_MSK_CUM_WRN_CLS];
			warn_pcb_bus_off <= parallel_control_bus_en && pcb_bus_off;
			warn_pcb_addr_dup <= parallel_control_bus_en && pcb_addr_dup;
			warn_pcb_gen_count <= parallel_control_bus_en && (pcb_gen_expected != 8'h00)
				&& (pcb_gen_count != pcb_gen_expected);
			neg_seq_current <= (mag3 > 32'h0000ffff) ? 16'hffff : mag3[15:0];
			deact_neg_seq <= ns_exp;
			anom_earth_close_fail <= ec_exp;
			earth_close_fail_action <= earth_close_action;
			warn_earth_open_fail <= eo_exp;
			anom_power_err <= pe_exp;
			// overrides demote the configured action to a warning
			power_err_action_out <= (prot_override || total_override) ? `GAM_ACT_WARN
				: power_err_action;
			if (gl_set) begin
				warn_grid_limit <= 1'b1;
			end else if (operator_ack && !gl_exp) begin
				warn_grid_limit <= 1'b0;
			end
			// transfer case: no forced open, auto close once load fits
			generator_breaker_force_open <= (warn_grid_limit || gl_set) && !gen_transfer_active;
			generator_breaker_auto_close <= warn_grid_limit && gen_transfer_active
				&& load_fits_gen;
			mains_breaker_open_permit <= (warn_grid_limit || gl_set) && (perm_mode
				|| (master_breaker_open_fail && mains_perm_mask[`GAM_PERM_MASTER]));
		end
	end
endmodule // gam_monitor

// [gam_mon_chk.sv]
// gam_mon_chk.sv: port-level assertions for the anomaly monitor
// assumes registered outputs that follow their inputs one clock later
`timescale 1ns/1ps
module gam_mon_chk (
	input logic clk,
	input logic nrst,
	input logic eng_bus_active,
	input logic ecu_oil_temp_high,
	input logic [15:0] can_disable_mask,
	input logic parallel_control_bus_en,
	input logic pcb_bus_off,
	input logic [7:0] pcb_gen_expected,
	input logic [1:0] op_mode,
	input logic warn_oil_temp_high,
	input logic alarm_oil_temp_max,
	input logic warn_water_in_fuel,
	input logic warn_bus_cumulative,
	input logic anom_bus_alarm,
	input logic anom_bus_alarm_is_warn,
	input logic warn_pcb_bus_off,
	input logic warn_pcb_gen_count,
	input logic anom_earth_close_fail,
	input logic warn_earth_open_fail
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	AST_OIL_HI: assert property (eng_bus_active && ecu_oil_temp_high && !can_disable_mask[2] |=> warn_oil_temp_high)
		else $error("oil warning missing");
	AST_NO_ENG: assert property (!eng_bus_active |=> !(warn_oil_temp_high || alarm_oil_temp_max || warn_water_in_fuel))
		else $error("engine report while bus off");
	AST_CUM_WRN: assert property (can_disable_mask[14] |=> !warn_bus_cumulative)
		else $error("masked cumulative warning");
	AST_CUM_ALM: assert property (can_disable_mask[15] [*2] |-> !anom_bus_alarm)
		else $error("masked cumulative alarm");
	AST_CLASS: assert property (anom_bus_alarm |-> anom_bus_alarm_is_warn == $past(can_disable_mask[13]))
		else $error("alarm class wrong");
	AST_BUS_OFF: assert property (parallel_control_bus_en && pcb_bus_off |=> warn_pcb_bus_off)
		else $error("bus off warning missing");
	AST_COUNT: assert property (pcb_gen_expected == 8'h00 |=> !warn_pcb_gen_count)
		else $error("count check not disabled");
	AST_MAN: assert property ((op_mode == 2'h0) [*2] |-> !anom_earth_close_fail && !warn_earth_open_fail)
		else $error("earth check in manual");
	cover property (anom_bus_alarm && anom_bus_alarm_is_warn);
	cover property (warn_pcb_gen_count);
	cover property (warn_oil_temp_high && warn_bus_cumulative);
endmodule // gam_mon_chk

bind gam_monitor gam_mon_chk gam_mon_chk_inst (.*);

// [gam_far_end.sv]
// gam_far_end.sv: engine unit, regulator, mixer and peer boards as report bits
// assumes the bench only requests cumulative warning and alarm reports from units that sit on the bus
`timescale 1ns/1ps
module gam_far_end (
	input logic clk,
	input logic slow,
	input logic [18:0] ev,
	output logic [18:0] rep
);
	logic [18:0] cap;
	// reports change just after the edge, early or late, never near the next one
	always @(posedge clk) begin
		cap = ev;
		#(slow ? 4 : 1);
		rep <= cap;
	end
endmodule // gam_far_end

// [test_genset_anomaly_monitor.sv]
// test_genset_anomaly_monitor.sv: random and directed checks of the anomaly monitor
// assumes second timers never expire within this short run
`timescale 1ns/1ps
module test_genset_anomaly_monitor;
	logic clk, nrst, slow, eng_bus_active, avr_bus_cfg, mixer_bus_cfg, parallel_control_bus_en, fuel_active;
	logic engine_start_stop, current_on_gen, volt_rot_ccw, earth_breaker_output_func, earth_feedback_input_func;
	logic earth_close_cmd, earth_open_cmd, earth_fb_closed, in_parallel, prot_override, total_override;
	logic grid_parallel, master_breaker_open_fail, gen_transfer_active, load_fits_gen, operator_ack;
	logic ecu_oil_temp_high, ecu_oil_temp_max, ecu_water_in_fuel, ecu_any_warn, avr_any_warn, mixer_any_warn;
	logic ecu_any_alarm, avr_any_alarm, mixer_any_alarm, pcb_bus_off, pcb_addr_dup;
	logic [1:0] phase_seq_sel, op_mode, earth_close_action, power_err_action, power_err_action_out;
	logic [1:0] earth_close_fail_action;
	logic [3:0] phase_count;
	logic [7:0] pcb_gen_count, pcb_gen_expected, mains_perm_mask;
	logic [15:0] can_disable_mask, neg_seq_limit, neg_seq_delay_s, earth_fb_delay_s, power_err_thresh, grid_limit_s;
	logic [15:0] neg_seq_current;
	logic signed [15:0] i1_re, i1_im, i2_re, i2_im, i3_re, i3_im, power_delivered, power_setpoint;
	logic warn_oil_temp_high, alarm_oil_temp_max, warn_water_in_fuel, warn_bus_cumulative, anom_bus_alarm;
	logic anom_bus_alarm_is_warn, warn_pcb_bus_off, warn_pcb_addr_dup, warn_pcb_gen_count, deact_neg_seq;
	logic anom_earth_close_fail, warn_earth_open_fail, anom_power_err, warn_grid_limit;
	logic generator_breaker_force_open, generator_breaker_auto_close, mains_breaker_open_permit;
	logic [18:0] ev, rep;
	logic [31:0] v [10];
	int bad_count, samples_checked, e;
	wire [15:0] seen = {7'h00, warn_oil_temp_high, alarm_oil_temp_max, warn_water_in_fuel, warn_bus_cumulative,
		anom_bus_alarm, anom_bus_alarm_is_warn, warn_pcb_bus_off, warn_pcb_addr_dup, warn_pcb_gen_count};

	gam_monitor gam_monitor_inst (.*);
	gam_far_end gam_far_end_inst (.clk(clk), .slow(slow), .ev(ev), .rep(rep));
	assign {ecu_oil_temp_high, ecu_oil_temp_max, ecu_water_in_fuel, ecu_any_warn, avr_any_warn, mixer_any_warn,
		ecu_any_alarm, avr_any_alarm, mixer_any_alarm, pcb_bus_off, pcb_addr_dup, pcb_gen_count} = rep;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task chk(input logic [15:0] got, input logic [15:0] exp, input int tol);
		samples_checked++;
		if ($isunknown(got) || got > exp + tol || got + tol < exp) begin
			bad_count++;
			$display("ERROR %0t: got %0d expected %0d", $time, got, exp);
		end
	endtask

	function logic [15:0] exp_bus();
		logic [15:0] m;
		logic e, c, p;
		m = can_disable_mask;
		e = eng_bus_active;
		c = e | avr_bus_cfg | mixer_bus_cfg;
		p = parallel_control_bus_en;
		return {7'h00, e & ecu_oil_temp_high & ~m[2], e & ecu_oil_temp_max & ~m[3], e & ecu_water_in_fuel & ~m[8],
			c & (ecu_any_warn | avr_any_warn | mixer_any_warn) & ~m[14],
			c & (ecu_any_alarm | avr_any_alarm | mixer_any_alarm) & ~m[15], m[13], p & pcb_bus_off,
			p & pcb_addr_dup, p & (pcb_gen_expected != 8'h00) & (pcb_gen_count != pcb_gen_expected)};
	endfunction

	// exact third of the rotated phasor sum; ccw puts 240 on phase two and 120 on phase three
	function int ns_exp(input int a_re, input int a_im, input int b_re, input int b_im, input int c_re,
		input int c_im, input bit ccw);
		real t2, t3, re, im;
		t2 = (ccw ? 240.0 : 120.0) * 3.14159265358979 / 180.0;
		t3 = (ccw ? 120.0 : 240.0) * 3.14159265358979 / 180.0;
		re = a_re + b_re * $cos(t2) - b_im * $sin(t2) + c_re * $cos(t3) - c_im * $sin(t3);
		im = a_im + b_re * $sin(t2) + b_im * $cos(t2) + c_re * $sin(t3) + c_im * $cos(t3);
		return $rtoi($sqrt(re * re + im * im) / 3.0 + 0.5);
	endfunction

	task apply;
		{fuel_active, engine_start_stop, current_on_gen, volt_rot_ccw, earth_breaker_output_func,
			earth_feedback_input_func, earth_close_cmd, earth_open_cmd, earth_fb_closed, in_parallel, prot_override,
			total_override, grid_parallel, master_breaker_open_fail, gen_transfer_active, load_fits_gen, operator_ack,
			op_mode, earth_close_action, power_err_action, phase_seq_sel, phase_count} = v[0][28:0];
		{neg_seq_limit, neg_seq_delay_s} = v[1];
		{earth_fb_delay_s, grid_limit_s} = v[2];
		{power_delivered, power_setpoint} = v[3];
		{power_err_thresh, i1_re} = v[4];
		{i1_im, i2_re} = v[5];
		{i2_im, i3_re} = v[6];
		{i3_im, can_disable_mask} = v[7];
		{eng_bus_active, avr_bus_cfg, mixer_bus_cfg, parallel_control_bus_en, slow} = v[8][4:0];
		pcb_gen_expected = {6'h00, v[8][6:5]};
		mains_perm_mask = 8'h00;
		// only units present on the bus can report cumulative warnings or alarms
		ev = {v[9][18:16], v[9][15:13] & {eng_bus_active, avr_bus_cfg, mixer_bus_cfg},
			v[9][12:10] & {eng_bus_active, avr_bus_cfg, mixer_bus_cfg}, v[9][9:8],
			v[8][7] ? pcb_gen_expected : {6'h00, v[9][1:0]}};
	endtask

	task results;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		#200000;
		bad_count++;
		$display("ERROR %0t: watchdog expired", $time);
		results();
	end

	initial begin
		nrst = 1'b0;
		foreach (v[k]) v[k] = 32'h0;
		apply();
		void'($urandom(32'h5030a35f));
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		// one phase at 0 deg, one at 120 deg: sequence choice decides the sum
		i1_re = 16'sd1000;
		i2_re = -16'sd500;
		i2_im = 16'sd866;
		for (int k = 0; k < 5; k++) begin
			@(negedge clk);
			phase_seq_sel = k[1:0];
			volt_rot_ccw = k[2];
			@(negedge clk);
			chk(neg_seq_current, 16'(ns_exp(1000, 0, -500, 866, 0, 0, k == 2 || k == 4)), 8);
		end
		for (int n = 0; n < 300; n++) begin
			@(negedge clk);
			foreach (v[k]) v[k] = $urandom;
			if (n < 2) begin
				v[7][15:0] = n ? 16'hffff : 16'h0000;
				v[8][3:0] = 4'hf;
			end
			apply();
			@(negedge clk);
			@(negedge clk);
			chk(seen, exp_bus(), 0);
			e = ns_exp(i1_re, i1_im, i2_re, i2_im, i3_re, i3_im,
				phase_seq_sel == 2'h2 || (phase_seq_sel == 2'h0 && volt_rot_ccw));
			chk(neg_seq_current, 16'(e), e / 16 + 4);
			chk({14'h0000, power_err_action_out},
				{14'h0000, ((prot_override || total_override) ? 2'h0 : power_err_action)}, 0);
			chk({14'h0000, earth_close_fail_action}, {14'h0000, earth_close_action}, 0);
			// every timed condition is far younger than one second here, so nothing may have expired
			chk({8'h00, deact_neg_seq, anom_earth_close_fail, warn_earth_open_fail, anom_power_err, warn_grid_limit,
				generator_breaker_force_open, generator_breaker_auto_close, mains_breaker_open_permit},
				16'h0000, 0);
		end
		nrst = 1'b0;
		@(negedge clk);
		chk(seen, 16'h0000, 0);
		nrst = 1'b1;
		@(negedge clk);
		results();
	end
endmodule // test_genset_anomaly_monitor
